/* File: logic/wwd_timer.sv */
// windowed watchdog: 8-bit up counter on a divided clock, clear window, nmi or reset on overflow
// assumes same-clock register port, mode inputs from the power manager already synchronous
//
// Operation
// RULE1: action select zero makes each counter overflow raise an interrupt request
// RULE2: the interrupt request is non-maskable, independent of master enable
// RULE3: a new watchdog interrupt preempts any interrupt in service
// RULE4: action select one makes overflow raise a chip reset request
// RULE5: clear code write zeroes the counter, counting continues
// RULE6: disable code stops the watchdog only when count enable is zero
// RULE7: software clears inside the window before overflow
// RULE8: clear code coinciding with overflow clears and suppresses overflow
// RULE9: counter monitor read returns the live counter value
// RULE10: operating state flag reads one when enabled, zero when disabled
// RULE11: overflow interrupt flag sets on overflow-caused interrupt
// RULE12: window violation flag sets on clear attempt outside window
// RULE13: status read clears both cause flags
// RULE14: set condition coinciding with status read wins
// RULE15: enable bit starts counting, resets to one, disabling zeroes counter
// RULE16: window 00 allows clears any time, else early clear interrupts
// RULE17: two-bit time select picks four growing overflow periods
// RULE18: counter holds in stop, idle and sleep modes
// RULE19: overflow is wrap from all ones to zero, counting continues
`include "wwd_map.svh"
`timescale 1ns/100ps
`default_nettype none
module wwd_timer #(
   parameter int DIV_WIDTH = 16
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic low_power_hold,
   output logic [7:0] rdata,
   output logic nmi_req,
   output logic chip_reset_req
);
   wwd_pkg::wwd_byte_t watchdog_control_reg;
   logic [DIV_WIDTH-1:0] div_reg;
   logic [7:0] count_reg;
   logic active_reg;
   logic overflow_irq_flag;
   logic window_violation_flag;
   logic tick;
   logic overflow;
   logic clear_hit;
   logic disable_hit;
   logic early_clear;
   logic in_window;
   logic [1:0] time_sel;
   wwd_pkg::wwd_window_e win_sel;

   // tap of the prescaler chosen by the time select; each step quarters the rate
   function automatic logic div_tap(input logic [DIV_WIDTH-1:0] d, input logic [1:0] sel);
      div_tap = d[`WWD_DIV_BASE + 2 * sel - 1];
   endfunction

   assign time_sel = watchdog_control_reg[`WWD_CTL_TIME_HI:`WWD_CTL_TIME_LO];
   assign win_sel = wwd_pkg::wwd_window_e'(watchdog_control_reg[`WWD_CTL_WIN_HI:`WWD_CTL_WIN_LO]);
   assign clear_hit = wr && addr == `WWD_ADDR_CODE && wdata == `WWD_CODE_CLEAR;
   assign disable_hit = wr && addr == `WWD_ADDR_CODE && wdata == `WWD_CODE_DISABLE
                        && !watchdog_control_reg[`WWD_CTL_EN_BIT]; // [RULE6]
   // tick only on the rising edge of the selected prescaler tap
   assign tick = active_reg && !low_power_hold && (div_reg[`WWD_DIV_BASE + 2 * time_sel - 1] == 1'b0)
                 && div_tap(div_reg + DIV_WIDTH'(1), time_sel); // [RULE17] [RULE18]
   assign overflow = tick && count_reg == `WWD_COUNT_MAX && !clear_hit && !disable_hit; // [RULE8] [RULE19]

   always_comb
   begin
      case (win_sel)
         wwd_pkg::WWD_WIN_ANY: in_window = 1'b1; // [RULE16]
         wwd_pkg::WWD_WIN_HALF: in_window = count_reg[7];
         wwd_pkg::WWD_WIN_QUARTER: in_window = &count_reg[7:6];
         wwd_pkg::WWD_WIN_EIGHTH: in_window = &count_reg[7:5];
         default: in_window = 1'b1;
      endcase
   end
   assign early_clear = clear_hit && active_reg && !in_window; // [RULE16]

   always_ff @(posedge clk)
   begin
      if (reset)
         watchdog_control_reg <= `WWD_CTL_RESET; // [RULE15]
      else if (wr && addr == `WWD_ADDR_CONTROL)
         watchdog_control_reg <= wdata;
   end

   // operation state: re-enabled by setting the enable bit, stopped only by the disable code
   always_ff @(posedge clk)
   begin
      if (reset)
         active_reg <= 1'b1;
      else if (disable_hit)
         active_reg <= 1'b0; // [RULE6]
      else if (watchdog_control_reg[`WWD_CTL_EN_BIT])
         active_reg <= 1'b1; // [RULE15]
   end

   // prescaler frozen in low-power modes so the counter phase is kept
   always_ff @(posedge clk)
   begin
      if (reset || !active_reg)
         div_reg <= '0;
      else if (!low_power_hold)
         div_reg <= div_reg + DIV_WIDTH'(1); // [RULE18]
   end

   always_ff @(posedge clk)
   begin
      if (reset || disable_hit || !active_reg)
         count_reg <= '0; // [RULE15]
      else if (clear_hit && !early_clear)
         count_reg <= '0; // [RULE5] [RULE8]
      else if (tick)
         count_reg <= count_reg + 8'h01; // [RULE19]
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         nmi_req <= 1'b0;
      else
         nmi_req <= (overflow && !watchdog_control_reg[`WWD_CTL_ACT_BIT]) || early_clear; // [RULE1] [RULE2] [RULE3]
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         chip_reset_req <= 1'b0;
      else
         chip_reset_req <= overflow && watchdog_control_reg[`WWD_CTL_ACT_BIT]; // [RULE4]
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         overflow_irq_flag <= 1'b0;
      else if (overflow && !watchdog_control_reg[`WWD_CTL_ACT_BIT])
         overflow_irq_flag <= 1'b1; // [RULE11] [RULE14]
      else if (rd && addr == `WWD_ADDR_STATE)
         overflow_irq_flag <= 1'b0; // [RULE13]
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         window_violation_flag <= 1'b0;
      else if (early_clear)
         window_violation_flag <= 1'b1; // [RULE12] [RULE14]
      else if (rd && addr == `WWD_ADDR_STATE)
         window_violation_flag <= 1'b0; // [RULE13]
   end

   // unmapped and write-only addresses read as zero
   always_ff @(posedge clk)
   begin
      if (reset)
         rdata <= 8'h00;
      else if (rd)
      begin
         case (addr)
            `WWD_ADDR_CONTROL: rdata <= watchdog_control_reg;
            `WWD_ADDR_COUNT: rdata <= count_reg; // [RULE9]
            `WWD_ADDR_STATE: rdata <= {`WWD_STATE_UPPER, overflow_irq_flag, window_violation_flag,
                                       active_reg}; // [RULE10]
            default: rdata <= 8'h00;
         endcase
      end
      else
         rdata <= 8'h00;
   end

   a_clear_zeroes: assert property (@(posedge clk) disable iff (reset)
      clear_hit && !early_clear |=> count_reg == 8'h00) // [RULE5]
      else $error("clear code did not zero counter");
   a_disable_stops: assert property (@(posedge clk) disable iff (reset)
      disable_hit |=> !active_reg && count_reg == 8'h00) // [RULE6]
      else $error("disable code did not stop watchdog");
   a_nmi_overflow: assert property (@(posedge clk) disable iff (reset)
      tick && count_reg == `WWD_COUNT_MAX && !clear_hit && !disable_hit && !watchdog_control_reg[`WWD_CTL_ACT_BIT]
      |=> nmi_req && overflow_irq_flag) // [RULE1]
      else $error("overflow in interrupt mode gave no nmi");
   a_reset_overflow: assert property (@(posedge clk) disable iff (reset)
      overflow && watchdog_control_reg[`WWD_CTL_ACT_BIT] |=> chip_reset_req && !nmi_req) // [RULE4]
      else $error("overflow in reset mode gave no reset request");
   a_clear_beats_ovf: assert property (@(posedge clk) disable iff (reset)
      clear_hit && !early_clear |=> !chip_reset_req && !overflow_irq_flag || $past(overflow_irq_flag)) // [RULE8]
      else $error("overflow detected despite clear");
   a_window_flag: assert property (@(posedge clk) disable iff (reset)
      early_clear |=> window_violation_flag && nmi_req && count_reg != 8'h00 || $past(count_reg) == 8'h00) // [RULE12]
      else $error("early clear not flagged");
   a_read_clears: assert property (@(posedge clk) disable iff (reset)
      rd && addr == `WWD_ADDR_STATE && !overflow && !early_clear |=> !overflow_irq_flag && !window_violation_flag) // [RULE13]
      else $error("status read did not clear flags");
   a_set_wins: assert property (@(posedge clk) disable iff (reset)
      rd && addr == `WWD_ADDR_STATE && early_clear |=> window_violation_flag) // [RULE14]
      else $error("set lost against status read");
   a_hold_counter: assert property (@(posedge clk) disable iff (reset)
      low_power_hold && !wr ##1 low_power_hold |-> $stable(count_reg)) // [RULE18]
      else $error("counter moved in low power mode");
   a_count_read: assert property (@(posedge clk) disable iff (reset)
      rd && addr == `WWD_ADDR_COUNT |=> rdata == $past(count_reg)) // [RULE9]
      else $error("counter read mismatch");
   c_overflow_nmi: cover property (@(posedge clk) nmi_req && overflow_irq_flag);
   c_overflow_reset: cover property (@(posedge clk) chip_reset_req);
   c_early_clear: cover property (@(posedge clk) early_clear);
   c_disable: cover property (@(posedge clk) disable_hit);
endmodule
`default_nettype wire

/* File: logic/wwd_map.svh */
// register offsets, field positions, codes and reset values of the windowed watchdog
// assumes inclusion by bare name from the design file
`ifndef WWD_MAP_SVH
`define WWD_MAP_SVH
`define WWD_ADDR_CONTROL 4'h4
`define WWD_ADDR_CODE 4'h5
`define WWD_ADDR_COUNT 4'h6
`define WWD_ADDR_STATE 4'h7
`define WWD_CODE_CLEAR 8'h4E
`define WWD_CODE_DISABLE 8'hB1
`define WWD_CTL_EN_BIT 7
`define WWD_CTL_WIN_HI 6
`define WWD_CTL_WIN_LO 5
`define WWD_CTL_TIME_HI 4
`define WWD_CTL_TIME_LO 3
`define WWD_CTL_ACT_BIT 1
`define WWD_CTL_RESET 8'h80
`define WWD_STATE_UPPER 5'h0B
`define WWD_COUNT_MAX 8'hFF
`define WWD_DIV_BASE 8
`endif

/* File: logic/wwd_pkg.sv */
// types shared by the windowed watchdog design
// assumes the map header for numeric constants
package wwd_pkg;
   typedef enum logic [1:0] {WWD_WIN_ANY, WWD_WIN_HALF, WWD_WIN_QUARTER, WWD_WIN_EIGHTH} wwd_window_e;
   typedef logic [7:0] wwd_byte_t;
endpackage

/* File: dv/wwd_cpu_side.sv */
// model of the cpu core and reset controller beside the watchdog: counts accepted requests
// assumes requests are one-cycle pulses on the block clock
`timescale 1ns/100ps
`default_nettype none
module wwd_cpu_side (
   input wire logic clk,
   input wire logic reset,
   input wire logic nmi_req,
   input wire logic chip_reset_req,
   output var int nmi_count,
   output var int reset_count
);
   initial
   begin
      nmi_count = 0;
      reset_count = 0;
   end
   // no mask and no in-service gate: every pulse adds one to its request count
   always @(posedge clk)
   begin
      if (!reset && nmi_req === 1'b1)
         nmi_count <= nmi_count + 1;
      if (!reset && chip_reset_req === 1'b1)
         reset_count <= reset_count + 1;
   end
endmodule
`default_nettype wire

/* File: dv/windowed_watchdog_timer_test.sv */
// self-checking bench for the windowed watchdog, with an integer model of the status flags
// assumes the design's register port and the cpu side model
`timescale 1ns/100ps
`default_nettype none
module windowed_watchdog_timer_test;
   logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, low_power_hold = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata, v, c1;
   logic nmi_req, chip_reset_req;
   int nmi_count, reset_count, failures = 0, compares = 0, cycles = 0, ovf = 0, win = 0, act = 1, n0, i;
   integer seed = 32'hf2b7;
   wwd_timer #(.DIV_WIDTH(16)) dut_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .low_power_hold(low_power_hold), .rdata(rdata), .nmi_req(nmi_req), .chip_reset_req(chip_reset_req));
   wwd_cpu_side cpu_u (.clk(clk), .reset(reset), .nmi_req(nmi_req), .chip_reset_req(chip_reset_req),
      .nmi_count(nmi_count), .reset_count(reset_count));
   always #10 clk = ~clk;
   // the longest wait is one full overflow period of 65536 cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 90000)
      begin
         failures++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (failures == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // status read: model value compared, then the model's cause flags clear
   task automatic status_chk();
      bus_rd(4'h7, v);
      check("status", v, {5'h0B, ovf[0], win[0], act[0]});
      ovf = 0;
      win = 0;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      status_chk();
      bus_rd(4'h4, v);
      check("control", v, 8'h80);
      bus_rd(4'h0, v);
      check("unmapped", v, 8'h00);
      bus_wr(4'h4, 8'hA0);
      n0 = nmi_count;
      bus_wr(4'h5, 8'h4E);
      win = 1;
      // the cpu model counts on the edge after the pulse; look once that count has settled
      @(posedge clk);
      #1;
      check("early clear nmi", nmi_count - n0, 8'h01);
      bus_rd(4'h6, v);
      check("count kept", v & 8'hFE, 8'h00);
      status_chk();
      status_chk();
      bus_wr(4'h4, 8'h80);
      for (i = 0; i < 4; i++)
      begin
         v = $random(seed);
         if (v == 8'h4E || v == 8'hB1)
            v = 8'h00;
         bus_wr(4'h5, v);
         bus_wr(4'h6, v);
      end
      bus_wr(4'h5, 8'h4E);
      bus_rd(4'h6, v);
      check("count cleared", v & 8'hFE, 8'h00);
      @(posedge clk);
      low_power_hold <= 1'b1;
      bus_rd(4'h6, c1);
      repeat (1000) @(posedge clk);
      bus_rd(4'h6, v);
      check("count held", v, c1);
      @(posedge clk);
      low_power_hold <= 1'b0;
      bus_wr(4'h5, 8'hB1);
      status_chk();
      bus_wr(4'h4, 8'h00);
      bus_wr(4'h5, 8'hB1);
      act = 0;
      status_chk();
      bus_rd(4'h6, v);
      check("count off", v, 8'h00);
      bus_wr(4'h4, 8'h80);
      act = 1;
      n0 = nmi_count;
      for (i = 0; i < 70000 && nmi_count == n0; i++)
         @(posedge clk);
      ovf = 1;
      check("overflow nmi", nmi_count - n0, 8'h01);
      check("no reset", reset_count, 8'h00);
      status_chk();
      bus_rd(4'h6, v);
      check("count wrapped", v, 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
